// ---- logic/dfl_pkg.sv ----
// Purpose: shared constants and types of the drive fault latch and indicator
// Assumes: 125 MHz system clock, plain register port with byte addresses
// Notes: all counts derived from times named here
package dfl_pkg;

    // clock and indicator timing
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned CYCLE_S = 4;
    localparam int unsigned BLINK_MS = 250;
    localparam int unsigned CYCLE_CYC = CLK_HZ * CYCLE_S;
    localparam int unsigned BLINK_CYC = (CLK_HZ / MS_PER_S) * BLINK_MS;
    localparam int CNT_W = 29;
    localparam int SLOT_W = 4;

    // fault vector layout
    localparam int NFAULT = 3;
    localparam int F_OC = 0;
    localparam int F_OV = 1;
    localparam int F_PE = 2;

    // blink counts per fault
    localparam logic [2:0] CODE_NONE = 3'h0;
    localparam logic [2:0] CODE_OC = 3'h1;
    localparam logic [2:0] CODE_OV = 3'h2;
    localparam logic [2:0] CODE_PE = 3'h7;

    // position error limit after reset, in pulses (1000)
    localparam logic [31:0] LIMIT_RST = 32'h0000_03E8;

    // register port
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] REG_MASK = 8'h04;
    localparam logic [ADDR_W-1:0] REG_LIMIT = 8'h08;
    localparam logic [ADDR_W-1:0] REG_FAULT = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_CMD_POS = 8'h10;
    localparam logic [ADDR_W-1:0] REG_ACT_POS = 8'h14;
    localparam logic [ADDR_W-1:0] REG_TRACK_ERR = 8'h18;
    localparam logic [ADDR_W-1:0] REG_PEAK_ERR = 8'h1C;

    // field positions of the fault register
    localparam int FLD_CODE_LO = 4;
    localparam int FLD_DRIVE = 8;

    // pin vector layout
    localparam int NPIN = 5;
    localparam int P_OC = 0;
    localparam int P_SHORT = 1;
    localparam int P_OV = 2;
    localparam int P_STEP = 3;
    localparam int P_DIR = 4;

    typedef logic [NFAULT-1:0] dfl_faults_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } dfl_bus_req_t;

    typedef enum logic [0:0] {
        ST_RUN = 1'b0,
        ST_TRIP = 1'b1
    } dfl_state_t;

endpackage

// ---- logic/dfl_blink_gen.sv ----
// Purpose: blink pattern generator for the red fault indicator
// Assumes: code input from logic on the same clock
// Notes: blink count is taken at the start of each cycle
`timescale 1ns/1ps
`default_nettype none
module dfl_blink_gen import dfl_pkg::*; #(
    parameter int unsigned CYCLE_CYCLES = CYCLE_CYC,
    parameter int unsigned BLINK_CYCLES = BLINK_CYC
) (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic ce_in,
    input wire logic [2:0] code_in,
    output logic led_out
);

    typedef struct packed {
        logic [CNT_W-1:0] period;
        logic [CNT_W-1:0] half;
        logic [SLOT_W-1:0] slot;
        logic [2:0] code;
        logic led;
    } dfl_blink_st_t;

    localparam logic [CNT_W-1:0] PERIOD_LAST = CNT_W'(CYCLE_CYCLES - 1);
    localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(BLINK_CYCLES - 1);
    localparam logic [SLOT_W-1:0] SLOT_MAX = '1;

    dfl_blink_st_t s;
    dfl_blink_st_t next_s;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_s = s;
        if (s.code == CODE_NONE || s.period == PERIOD_LAST) begin
            // new cycle; blinking starts at its head
            next_s.period = '0;
            next_s.half = '0;
            next_s.slot = '0;
            next_s.code = code_in;
        end else begin
            next_s.period = s.period + 1'b1;
            if (s.half == HALF_LAST) begin
                next_s.half = '0;
                if (s.slot != SLOT_MAX) begin
                    next_s.slot = s.slot + 1'b1;
                end
            end else begin
                next_s.half = s.half + 1'b1;
            end
        end
        // even slot lit, odd slot dark, then dark to cycle end
        next_s.led = ~next_s.slot[0] &&
            ({1'b0, next_s.slot[SLOT_W-1:1]} < {1'b0, next_s.code});
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            s <= '0;
        end else if (ce_in) begin
            s <= next_s;
        end
    end

    assign led_out = s.led;

endmodule
`default_nettype wire

// ---- logic/dfl_fault_latch.sv ----
// Purpose: fault latch, motor drive cut-off and red blink indicator
// Assumes: fault comparators and step pins are asynchronous, encoder count is
//          on the system clock, software uses the plain register port
// Notes: latched faults leave only by reset
//
// How it works
// - red LED repeats a 4 s cycle
// - priority over-current, over-voltage, then position error
// - over-current or short flag blinks once
// - over-voltage flag blinks twice
// - tracking error above limit blinks seven times
// - limit register, 1000 pulses after reset
// - any fault disables drive, indication continues
// - faults latched until power-up reset
// - error is the magnitude of commanded count minus encoder count
//
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module dfl_fault_latch import dfl_pkg::*; #(
    parameter int unsigned CYCLE_CYCLES = CYCLE_CYC,
    parameter int unsigned BLINK_CYCLES = BLINK_CYC
) (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic ce_in,
    input wire logic oc_flag_in,
    input wire logic short_flag_in,
    input wire logic ov_flag_in,
    input wire logic step_in,
    input wire logic dir_in,
    input wire logic [DATA_W-1:0] enc_pos_in,
    input wire dfl_bus_req_t bus_req_in,
    output logic [DATA_W-1:0] rd_data_out,
    output logic drive_en_out,
    output logic led_red_out,
    output logic irq_out
);

    typedef struct packed {
        logic [NPIN-1:0] sync1;
        logic [NPIN-1:0] sync2;
        logic step_d;
        logic [DATA_W-1:0] cmd_pos;
        logic [DATA_W-1:0] track_err;
        logic [DATA_W-1:0] peak_err;
        logic [DATA_W-1:0] limit;
        dfl_faults_t latched;
        dfl_faults_t status;
        dfl_faults_t mask;
        logic [2:0] code;
        dfl_state_t state;
        logic drive_en;
        logic irq;
        logic [DATA_W-1:0] rd_data;
    } dfl_st_t;

    dfl_st_t s;
    dfl_st_t next_s;

    ////////////////////////////////////////////////////////////////////////
    // highest-priority latched fault to blink count
    function automatic logic [2:0] fault_code(input dfl_faults_t f);
        logic [2:0] c;
        c = CODE_NONE;
        if (f[F_OC]) begin
            c = CODE_OC;
        end else if (f[F_OV]) begin
            c = CODE_OV;
        end else if (f[F_PE]) begin
            c = CODE_PE;
        end
        return c;
    endfunction

    function automatic logic [DATA_W-1:0] pad_faults(input dfl_faults_t f);
        return {{(DATA_W-NFAULT){1'b0}}, f};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic [NPIN-1:0] pins;
    logic step_rise;
    logic [DATA_W-1:0] diff;
    dfl_faults_t detect;
    dfl_faults_t w1c;
    logic [DATA_W-1:0] fault_word;

    assign pins = {dir_in, step_in, ov_flag_in, short_flag_in, oc_flag_in};

    always_comb begin
        next_s = s;
        w1c = '0;
        fault_word = '0;

        // two-stage synchronisers; only sync2 is used below
        next_s.sync1 = pins;
        next_s.sync2 = s.sync1;
        next_s.step_d = s.sync2[P_STEP];
        step_rise = s.sync2[P_STEP] & ~s.step_d;

        // commanded position from step pulses
        if (step_rise) begin
            if (s.sync2[P_DIR]) begin
                next_s.cmd_pos = s.cmd_pos - 1'b1;
            end else begin
                next_s.cmd_pos = s.cmd_pos + 1'b1;
            end
        end
        diff = s.cmd_pos - enc_pos_in;
        next_s.track_err = diff[DATA_W-1] ? (~diff + 1'b1) : diff;
        if (s.track_err > s.peak_err) begin
            next_s.peak_err = s.track_err;
        end

        // fault detection
        detect[F_OC] = s.sync2[P_OC] | s.sync2[P_SHORT];
        detect[F_OV] = s.sync2[P_OV];
        detect[F_PE] = s.track_err > s.limit;
        next_s.latched = s.latched | detect;

        // register writes
        if (bus_req_in.wr) begin
            unique case (bus_req_in.addr)
                REG_STATUS: w1c = bus_req_in.wdata[NFAULT-1:0];
                REG_MASK: next_s.mask = bus_req_in.wdata[NFAULT-1:0];
                REG_LIMIT: next_s.limit = bus_req_in.wdata;
                default: ;
            endcase
        end
        // set beats clear
        next_s.status = (s.status & ~w1c) | (detect & ~s.latched);

        // trip state
        unique case (s.state)
            ST_RUN: begin
                if (|next_s.latched) begin
                    next_s.state = ST_TRIP;
                end
            end
            ST_TRIP: next_s.state = ST_TRIP;
        endcase
        next_s.drive_en = ~|next_s.latched;
        next_s.code = fault_code(next_s.latched);
        next_s.irq = |(next_s.status & next_s.mask);

        // register reads, data only in the following cycle
        fault_word[NFAULT-1:0] = s.latched;
        fault_word[FLD_CODE_LO +: 3] = fault_code(s.latched);
        fault_word[FLD_DRIVE] = s.drive_en;
        next_s.rd_data = '0;
        if (bus_req_in.rd) begin
            unique case (bus_req_in.addr)
                REG_STATUS: next_s.rd_data = pad_faults(s.status);
                REG_MASK: next_s.rd_data = pad_faults(s.mask);
                REG_LIMIT: next_s.rd_data = s.limit;
                REG_FAULT: next_s.rd_data = fault_word;
                REG_CMD_POS: next_s.rd_data = s.cmd_pos;
                REG_ACT_POS: next_s.rd_data = enc_pos_in;
                REG_TRACK_ERR: next_s.rd_data = s.track_err;
                REG_PEAK_ERR: next_s.rd_data = s.peak_err;
                default: next_s.rd_data = '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            s <= '0;
            s.limit <= LIMIT_RST;
            s.state <= ST_RUN;
            s.drive_en <= 1'b1;
        end else if (ce_in) begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    dfl_blink_gen #(
        .CYCLE_CYCLES(CYCLE_CYCLES),
        .BLINK_CYCLES(BLINK_CYCLES)
    ) u_blink (
        .ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .ce_in(ce_in),
        .code_in(s.code),
        .led_out(led_red_out)
    );

    assign rd_data_out = s.rd_data;
    assign drive_en_out = s.drive_en;
    assign irq_out = s.irq;

endmodule
`default_nettype wire

// ---- verification/dfl_fault_latch_asserts.sv ----
// Purpose: port checks of the drive fault latch
// Assumes: ce_in held high, reset held at least two cycles
// Notes: bound into dfl_fault_latch
`timescale 1ns/1ps
`default_nettype none
module dfl_fault_latch_asserts import dfl_pkg::*; #(
    parameter int unsigned BLINK_CYCLES = BLINK_CYC
) (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic oc_flag_in,
    input wire logic short_flag_in,
    input wire logic ov_flag_in,
    input wire dfl_bus_req_t bus_req_in,
    input wire logic [DATA_W-1:0] rd_data_out,
    input wire logic drive_en_out,
    input wire logic led_red_out,
    input wire logic irq_out
);
    int unsigned on_cnt;
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    // length of the current lit run
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            on_cnt <= 32'h0;
        end else begin
            on_cnt <= led_red_out ? on_cnt + 32'h1 : 32'h0;
        end
    end
    sequence s_held3(logic s);
        s ##1 s ##1 s;
    endsequence
    a_oc_trip: assert property (s_held3(oc_flag_in) |-> ##[0:2] !drive_en_out)
        else $error("over-current did not cut drive");
    a_short_trip: assert property (s_held3(short_flag_in) |-> ##[0:2] !drive_en_out)
        else $error("short did not cut drive");
    a_ov_trip: assert property (s_held3(ov_flag_in) |-> ##[0:2] !drive_en_out)
        else $error("over-voltage did not cut drive");
    a_drive_stays_off: assert property (!drive_en_out |=> !drive_en_out)
        else $error("drive came back without reset");
    a_led_needs_fault: assert property (led_red_out |-> !drive_en_out)
        else $error("indicator lit with no fault");
    a_irq_needs_fault: assert property (irq_out |-> !drive_en_out)
        else $error("interrupt with no fault latched");
    a_blink_width: assert property ($fell(led_red_out) |-> on_cnt == BLINK_CYCLES)
        else $error("blink on time wrong");
    a_read_idle: assert property (!bus_req_in.rd |=> rd_data_out == '0)
        else $error("read data outside read answer");
endmodule
bind dfl_fault_latch dfl_fault_latch_asserts #(.BLINK_CYCLES(BLINK_CYCLES)) u_chk (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .oc_flag_in(oc_flag_in),
    .short_flag_in(short_flag_in), .ov_flag_in(ov_flag_in), .bus_req_in(bus_req_in),
    .rd_data_out(rd_data_out), .drive_en_out(drive_en_out), .led_red_out(led_red_out),
    .irq_out(irq_out)
);
`default_nettype wire

// ---- verification/dfl_plant.sv ----
// Purpose: step source and shaft encoder beside the fault latch
// Assumes: steps counted up, one every two clocks
// Notes: slip_in stalls the shaft to build tracking error
`timescale 1ns/1ps
`default_nettype none
module dfl_plant (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic drive_en_in,
    input wire logic run_in,
    input wire logic slip_in,
    output logic step_out,
    output logic dir_out,
    output logic [31:0] enc_pos_out
);
    assign dir_out = 1'b0;
    always @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            step_out <= 1'b0;
            enc_pos_out <= 32'h0;
        end else begin
            step_out <= run_in & ~step_out;
            // free or stalled shaft stops following
            if (run_in && !step_out && drive_en_in && !slip_in) begin
                enc_pos_out <= enc_pos_out + 32'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
// Purpose: self-checking bench of the drive fault latch
// Assumes: shortened indicator timing, ce_in held high
// Notes: one reset per fault case, since faults only leave by reset
`timescale 1ns/1ps
`default_nettype none
module tb_top import dfl_pkg::*;;
    localparam int unsigned CYC = 64;
    localparam int unsigned BL = 2;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic oc = 1'b0, sh = 1'b0, ov = 1'b0, slip = 1'b0, run = 1'b0;
    dfl_bus_req_t req = '0;
    logic [31:0] rdata, enc, lim, msk, exp_f;
    logic drive, led, irq, step, dir;
    int n_mismatch = 0, samples_checked = 0, cyc = 0, lat, n, m;
    logic [3:0] inj1 [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h8, 4'h4};
    logic [3:0] inj2 [6] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h4, 4'h1};
    dfl_fault_latch #(.CYCLE_CYCLES(CYC), .BLINK_CYCLES(BL)) dut (
        .ref_clk_in(clk), .sys_rst_in(rst), .ce_in(1'b1), .oc_flag_in(oc),
        .short_flag_in(sh), .ov_flag_in(ov), .step_in(step), .dir_in(dir),
        .enc_pos_in(enc), .bus_req_in(req), .rd_data_out(rdata), .drive_en_out(drive),
        .led_red_out(led), .irq_out(irq));
    dfl_plant u_plant (.ref_clk_in(clk), .sys_rst_in(rst), .drive_en_in(drive),
        .run_in(run), .slip_in(slip), .step_out(step), .dir_out(dir), .enc_pos_out(enc));
    always #4 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] e);
        samples_checked++;
        if (seen !== e) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req <= '0;
        @(posedge clk);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req <= '0;
        #1;
        chk(rdata, e);
        @(posedge clk);
    endtask
    // causes as {slip, ov, short, oc}; model latches them
    task automatic inject(input logic [3:0] v);
        oc <= v[0];
        sh <= v[1];
        ov <= v[2];
        slip <= v[3];
        run <= v[3];
        lat |= {v[3], v[2], v[0] | v[1]};
        repeat (60) @(posedge clk);
    endtask
    task automatic count_blinks();
        logic p;
        n = 0;
        m = 0;
        p = led;
        repeat (2 * CYC) begin
            @(posedge clk);
            #1;
            n += int'(led && !p);
            m += int'(led);
            p = led;
        end
        @(posedge clk);
    endtask
    function automatic int code_of(input int l);
        if (l[0]) return 1;
        if (l[1]) return 2;
        if (l[2]) return 7;
        return 0;
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h3B67));
        for (int k = 0; k < 6; k++) begin
            rst <= 1'b1;
            repeat (2) @(posedge clk);
            rst <= 1'b0;
            @(posedge clk);
            lat = 0;
            count_blinks();
            chk(32'(n), 32'h0);
            rc(REG_FAULT, 32'h100);
            rc(REG_LIMIT, 32'h3E8);
            lim = $urandom_range(10, 4);
            msk = $urandom_range(7, 0) | 32'(k == 0);
            wr(REG_LIMIT, lim);
            wr(REG_MASK, msk);
            rc(REG_LIMIT, lim);
            rc(8'h20, 32'h0);
            inject(inj1[k]);
            inject(inj2[k]);
            inject(4'h0);
            exp_f = 32'((code_of(lat) << FLD_CODE_LO) | lat);
            rc(REG_FAULT, exp_f);
            chk(32'(drive), 32'h0);
            chk(32'(irq), 32'((lat & msk) != 0));
            rc(REG_STATUS, lat);
            count_blinks();
            // window spans two full indicator cycles, so two bursts are seen
            chk(32'(n), 32'(2 * code_of(lat)));
            chk(32'(m), 32'(2 * BL * code_of(lat)));
            wr(REG_STATUS, 32'h7);
            rc(REG_STATUS, 32'h0);
            chk(32'(irq), 32'h0);
            rc(REG_FAULT, exp_f);
            $display("test %0d done", k);
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
